// [sacc_pkg.sv]
// Shared constants and types for the SAR converter calibration control.
// Assumes one core clock domain; analog pins are handled by the top.
`default_nettype none

package sacc_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] SFR_ADDR_CAL_CTRL = 8'hF5;
	localparam logic [7:0] CAL_CTRL_RESET    = 8'h00;
	localparam int         BUSY_BIT          = 7;
	localparam int         GAIN_DIS_BIT      = 6;
	localparam int         AVG_SEL_HI_BIT    = 5;
	localparam int         AVG_SEL_LO_BIT    = 4;
	localparam int         OFFSET_DIS_BIT    = 3;
	localparam int         CAL_MODE_BIT      = 2;
	localparam int         CAL_TYPE_BIT      = 1;
	localparam int         CAL_START_BIT     = 0;

	// ****************************************************************
	// Averaging codes and counts
	// ****************************************************************
	localparam logic [1:0] AVG_CODE_15  = 2'h0;
	localparam logic [1:0] AVG_CODE_1   = 2'h1;
	localparam logic [1:0] AVG_CODE_31  = 2'h2;
	localparam logic [4:0] AVG_COUNT_15 = 5'h0F;
	localparam logic [4:0] AVG_COUNT_1  = 5'h01;
	localparam logic [4:0] AVG_COUNT_31 = 5'h1F;
	localparam logic [4:0] AVG_COUNT_RSV = AVG_COUNT_15;

	// ****************************************************************
	// Converter clock divide ratios and timing
	// ****************************************************************
	localparam logic [1:0] DIV_CODE_8  = 2'h0;
	localparam logic [1:0] DIV_CODE_4  = 2'h1;
	localparam logic [1:0] DIV_CODE_16 = 2'h2;
	localparam logic [5:0] DIV_RATIO_8  = 6'h08;
	localparam logic [5:0] DIV_RATIO_4  = 6'h04;
	localparam logic [5:0] DIV_RATIO_16 = 6'h10;
	localparam logic [5:0] DIV_RATIO_32 = 6'h20;
	localparam int         CONV_PERIODS = 15;
	localparam int         SAR_BITS     = 12;
	localparam logic [1:0] TAIL_LAST    = 2'(CONV_PERIODS - SAR_BITS - 1);

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic       gain_coeff_disable;
		logic [1:0] cal_average_sel;
		logic       offset_coeff_disable;
		logic       cal_mode_select;
		logic       cal_type_select;
		logic       cal_start;
	} sacc_ctrl_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_SYNC = 5'b00010,
		ST_ACQ  = 5'b00100,
		ST_BIT  = 5'b01000,
		ST_TAIL = 5'b10000
	} sacc_state_type;

endpackage

`default_nettype wire

// [sacc_tick_gen.sv]
// Converter clock generator: one-cycle tick every selected core cycles.
// Assumes the ratio code comes from logic on the same clock.
`default_nettype none

module sacc_tick_gen
	import sacc_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Ratio select and tick
	input  wire logic [1:0] i_div_sel,
	output logic            o_tick
);

	logic [5:0] ratio;
	logic [5:0] count;
	logic       wrap;

	// ****************************************************************
	// Ratio decode
	// ****************************************************************
	assign ratio = (i_div_sel == DIV_CODE_8)  ? DIV_RATIO_8  :
	               (i_div_sel == DIV_CODE_4)  ? DIV_RATIO_4  :
	               (i_div_sel == DIV_CODE_16) ? DIV_RATIO_16 :
	                                            DIV_RATIO_32;
	// Compare with >= so a ratio drop mid-count cannot overrun
	assign wrap = (count >= ratio - 6'h01);

	// Divider counter
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count  <= 6'h00;
			o_tick <= 1'b0;
		end else begin
			count  <= wrap ? 6'h00 : count + 6'h01;
			o_tick <= wrap;
		end
	end

endmodule // sacc_tick_gen

`default_nettype wire

// [sacc_top.sv]
// Control of a successive-approximation converter with calibration.
// Assumes a core SFR port on I_CLK and an async comparator pin.
`default_nettype none

module sacc_top
	import sacc_pkg::*;
#(
	parameter int RES_BITS = SAR_BITS
)(
	// Clock and reset
	input  wire logic                I_CLK,
	input  wire logic                I_SYS_RST,
	// Special-function register port
	input  wire logic [7:0]          I_SFR_ADDR,
	input  wire logic [7:0]          I_SFR_WDATA,
	input  wire logic                I_SFR_WR,
	input  wire logic                I_SFR_RD,
	output logic      [7:0]          O_SFR_RDATA,
	// Timing settings and conversion start
	input  wire logic [1:0]          I_CLK_DIV_SEL,
	input  wire logic [1:0]          I_ACQ_SEL,
	input  wire logic                I_CONV_START,
	// Analog front end
	input  wire logic                I_CMP_HI,
	output logic                     O_TRACK,
	output logic      [RES_BITS-1:0] O_DAC_CODE,
	output logic                     O_CAL_ACTIVE,
	output logic                     O_CAL_FULL_SCALE,
	// Results
	output logic      [RES_BITS-1:0] O_RESULT,
	output logic                     O_RESULT_VALID,
	output logic                     O_BUSY
);

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (RES_BITS != SAR_BITS) begin : g_bad_width
		$error("RES_BITS must equal the SAR width of 12");
	end

	localparam logic [RES_BITS-1:0] FULL_CODE = '1;
	localparam logic [RES_BITS-1:0] MSB_CODE  = {1'b1, {(RES_BITS-1){1'b0}}};
	localparam logic [3:0]          MSB_IDX   = 4'(RES_BITS - 1);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic                cmp_meta, cmp_sync, tick, job_cal, idle;
	logic                wr_hit, rd_hit, cal_launch, conv_launch, finish;
	logic                last_read, keep_bit;
	sacc_ctrl_type       ctrl;
	sacc_state_type      state, next_state;
	logic [1:0]          acq_len, acq_cnt, next_acq_cnt;
	logic [1:0]          tail_cnt, next_tail_cnt;
	logic [3:0]          bit_idx, next_bit_idx;
	logic [4:0]          reads, next_reads, votes, next_votes;
	logic [4:0]          avg_count, n_reads, votes_now;
	logic [RES_BITS-1:0] sar, next_sar, offset_coef, gain_coef;
	logic [RES_BITS-1:0] off_used, gain_used, off_fixed, corrected;
	logic [RES_BITS:0]   gain_sum;
	logic [7:0]          ctrl_view;
	logic [2*RES_BITS-1:0] gain_prod;

	// ****************************************************************
	// Comparator synchroniser and converter clock
	// ****************************************************************
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= I_CMP_HI;
			cmp_sync <= cmp_meta;
		end
	end

	sacc_tick_gen u_tick (
		.i_clk     (I_CLK),
		.i_rst     (I_SYS_RST),
		.i_div_sel (I_CLK_DIV_SEL),
		.o_tick    (tick)
	);

	// ****************************************************************
	// Register decode and launch
	// ****************************************************************
	assign idle        = (state == ST_IDLE);
	assign wr_hit      = I_SFR_WR & (I_SFR_ADDR == SFR_ADDR_CAL_CTRL);
	assign rd_hit      = I_SFR_RD & (I_SFR_ADDR == SFR_ADDR_CAL_CTRL);
	// Start ignored while a cycle runs; mode bit is software's duty
	assign cal_launch  = wr_hit & I_SFR_WDATA[CAL_START_BIT] & idle;
	assign conv_launch = I_CONV_START & idle & ~cal_launch;
	assign finish      = (state == ST_TAIL) & tick & (tail_cnt == TAIL_LAST);
	assign ctrl_view   = {O_BUSY, ctrl};

	// ****************************************************************
	// Averaging count and bit decision
	// ****************************************************************
	assign avg_count = (ctrl.cal_average_sel == AVG_CODE_15) ? AVG_COUNT_15 :
	                   (ctrl.cal_average_sel == AVG_CODE_1)  ? AVG_COUNT_1  :
	                   (ctrl.cal_average_sel == AVG_CODE_31) ? AVG_COUNT_31 :
	                                                  AVG_COUNT_RSV;
	assign n_reads   = job_cal ? avg_count : AVG_COUNT_1;
	assign votes_now = votes + {4'h0, cmp_sync};
	assign last_read = (reads + 5'h01 >= n_reads);
	// Majority of an odd number of readings decides the bit
	assign keep_bit  = (votes_now > (n_reads >> 1));

	// ****************************************************************
	// Result correction
	// ****************************************************************
	assign off_used  = ctrl.offset_coeff_disable ? '0 : offset_coef;
	assign gain_used = ctrl.gain_coeff_disable   ? '0 : gain_coef;
	assign off_fixed = (sar > off_used) ? sar - off_used : '0;
	assign gain_prod = off_fixed * gain_used;
	assign gain_sum  = {1'b0, off_fixed} +
	                   {1'b0, gain_prod[2*RES_BITS-1:RES_BITS]};
	assign corrected = gain_sum[RES_BITS] ? FULL_CODE : gain_sum[RES_BITS-1:0];

	// ****************************************************************
	// Sequencer next state
	// ****************************************************************
	always_comb begin
		next_state    = state;
		next_acq_cnt  = acq_cnt;
		next_bit_idx  = bit_idx;
		next_reads    = reads;
		next_votes    = votes;
		next_tail_cnt = tail_cnt;
		next_sar      = sar;
		unique case (state)
			ST_IDLE: begin
				if (cal_launch | conv_launch) begin
					next_state = ST_SYNC;
				end
			end
			ST_SYNC: begin
				if (tick) begin
					next_state   = ST_ACQ;
					next_acq_cnt = 2'h0;
				end
			end
			ST_ACQ: begin
				if (tick) begin
					next_acq_cnt = acq_cnt + 2'h1;
					if (acq_cnt == acq_len) begin
						next_state   = ST_BIT;
						next_bit_idx = MSB_IDX;
						next_sar     = MSB_CODE;
						next_reads   = 5'h00;
						next_votes   = 5'h00;
					end
				end
			end
			ST_BIT: begin
				if (tick) begin
					next_reads = reads + 5'h01;
					next_votes = votes_now;
					if (last_read) begin
						next_reads = 5'h00;
						next_votes = 5'h00;
						next_sar[bit_idx] = keep_bit;
						if (bit_idx == 4'h0) begin
							next_state    = ST_TAIL;
							next_tail_cnt = 2'h0;
						end else begin
							next_bit_idx = bit_idx - 4'h1;
							next_sar[bit_idx - 4'h1] = 1'b1;
						end
					end
				end
			end
			ST_TAIL: begin
				if (tick) begin
					next_tail_cnt = tail_cnt + 2'h1;
					if (tail_cnt == TAIL_LAST) begin
						next_state = ST_IDLE;
					end
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			state    <= ST_IDLE;
			acq_cnt  <= 2'h0;
			bit_idx  <= 4'h0;
			reads    <= 5'h00;
			votes    <= 5'h00;
			tail_cnt <= 2'h0;
			sar      <= '0;
		end else begin
			state    <= next_state;
			acq_cnt  <= next_acq_cnt;
			bit_idx  <= next_bit_idx;
			reads    <= next_reads;
			votes    <= next_votes;
			tail_cnt <= next_tail_cnt;
			sar      <= next_sar;
		end
	end

	// Job kind and acquisition length caught at launch
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			job_cal <= 1'b0;
			acq_len <= 2'h0;
		end else if (cal_launch | conv_launch) begin
			job_cal <= cal_launch;
			acq_len <= I_ACQ_SEL;
		end
	end

	// ****************************************************************
	// Control register
	// ****************************************************************
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			ctrl <= sacc_ctrl_type'(CAL_CTRL_RESET[6:0]);
		end else begin
			if (wr_hit & idle) begin
				ctrl <= sacc_ctrl_type'(I_SFR_WDATA[6:0]);
			end else if (wr_hit) begin
				// Start bit stays held by hardware during a cycle
				ctrl <= sacc_ctrl_type'({I_SFR_WDATA[6:1], ctrl.cal_start});
			end
			if (finish & job_cal) begin
				ctrl.cal_start <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Coefficients, results and outputs
	// ****************************************************************
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			offset_coef    <= '0;
			gain_coef      <= '0;
			O_RESULT       <= '0;
			O_RESULT_VALID <= 1'b0;
		end else begin
			O_RESULT_VALID <= finish & ~job_cal;
			if (finish & ~job_cal) begin
				O_RESULT <= corrected;
			end
			if (finish & job_cal & ~ctrl.cal_type_select) begin
				offset_coef <= sar;
			end
			if (finish & job_cal & ctrl.cal_type_select) begin
				gain_coef <= FULL_CODE - off_fixed;
			end
		end
	end

	// Status and analog drive
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			O_BUSY           <= 1'b0;
			O_TRACK          <= 1'b0;
			O_DAC_CODE       <= '0;
			O_CAL_ACTIVE     <= 1'b0;
			O_CAL_FULL_SCALE <= 1'b0;
			O_SFR_RDATA      <= 8'h00;
		end else begin
			O_BUSY           <= (next_state != ST_IDLE);
			O_TRACK          <= (next_state == ST_ACQ);
			O_DAC_CODE       <= next_sar;
			O_CAL_ACTIVE     <= (next_state != ST_IDLE) &
			                    (cal_launch | (job_cal & ~idle));
			O_CAL_FULL_SCALE <= ctrl.cal_type_select;
			O_SFR_RDATA      <= rd_hit ? ctrl_view : 8'h00;
		end
	end

endmodule // sacc_top

`default_nettype wire

// [sacc_checker.sv]
// Port-level assertions for the converter calibration control top.
// Assumes a bind onto sacc_top; sees only that module's ports.
`default_nettype none

module sacc_checker
	import sacc_pkg::*;
#(
	parameter int RES_BITS = SAR_BITS
)(
	// Clock, reset and register port
	input wire logic                I_CLK,
	input wire logic                I_SYS_RST,
	input wire logic [7:0]          I_SFR_ADDR,
	input wire logic [7:0]          I_SFR_WDATA,
	input wire logic                I_SFR_WR,
	input wire logic                I_SFR_RD,
	input wire logic [7:0]          O_SFR_RDATA,
	// Timing and front end
	input wire logic [1:0]          I_CLK_DIV_SEL,
	input wire logic [1:0]          I_ACQ_SEL,
	input wire logic                I_CONV_START,
	input wire logic                I_CMP_HI,
	input wire logic                O_TRACK,
	input wire logic [RES_BITS-1:0] O_DAC_CODE,
	input wire logic                O_CAL_ACTIVE,
	input wire logic                O_CAL_FULL_SCALE,
	// Results
	input wire logic [RES_BITS-1:0] O_RESULT,
	input wire logic                O_RESULT_VALID,
	input wire logic                O_BUSY
);
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	// Address match, start request and expected conversion length
	wire logic        sel  = I_SFR_ADDR == SFR_ADDR_CAL_CTRL;
	wire logic        go   = I_SFR_WR && sel && I_SFR_WDATA[CAL_START_BIT];
	wire logic [5:0]  rat  = I_CLK_DIV_SEL == DIV_CODE_8  ? DIV_RATIO_8 :
		I_CLK_DIV_SEL == DIV_CODE_4 ? DIV_RATIO_4 :
		I_CLK_DIV_SEL == DIV_CODE_16 ? DIV_RATIO_16 : DIV_RATIO_32;
	wire logic [15:0] per  = 16'(rat) * (16'(I_ACQ_SEL) + 16'h0010);
	logic      [15:0] busy_cnt;

	// Busy cycle counter
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) busy_cnt <= 16'h0000;
		else busy_cnt <= O_BUSY ? busy_cnt + 16'h0001 : 16'h0000;
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	// ****************************************************************
	// Properties
	// ****************************************************************
	property p_rd_busy;
		I_SFR_RD && sel |=> O_SFR_RDATA[BUSY_BIT] == $past(O_BUSY);
	endproperty
	a_rd_busy: assert property (p_rd_busy)
		else $error("busy bit read back wrong");
	property p_rd_zero;
		!(I_SFR_RD && sel) |=> O_SFR_RDATA == 8'h00;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data not zero");
	property p_cal_go;
		go && !O_BUSY |=> O_BUSY && O_CAL_ACTIVE;
	endproperty
	a_cal_go: assert property (p_cal_go)
		else $error("calibration did not launch");
	property p_cal_type;
		go && !O_BUSY |-> ##2
			O_CAL_FULL_SCALE == $past(I_SFR_WDATA[CAL_TYPE_BIT], 2);
	endproperty
	a_cal_type: assert property (p_cal_type)
		else $error("calibration type wrong");
	property p_conv_go;
		I_CONV_START && !O_BUSY && !go |=> O_BUSY && !O_CAL_ACTIVE;
	endproperty
	a_conv_go: assert property (p_conv_go)
		else $error("conversion did not start");
	property p_valid;
		O_RESULT_VALID |-> !O_BUSY ##1 !O_RESULT_VALID;
	endproperty
	a_valid: assert property (p_valid)
		else $error("result pulse wrong");
	property p_res_hold;
		!O_RESULT_VALID |-> $stable(O_RESULT);
	endproperty
	a_res_hold: assert property (p_res_hold)
		else $error("result changed without pulse");
	property p_track;
		O_TRACK |-> O_BUSY;
	endproperty
	a_track: assert property (p_track)
		else $error("tracking while idle");
	property p_cal_busy;
		O_CAL_ACTIVE |-> O_BUSY;
	endproperty
	a_cal_busy: assert property (p_cal_busy)
		else $error("calibration without busy");
	property p_conv_len;
		$fell(O_BUSY) && !$past(O_CAL_ACTIVE) |->
			busy_cnt >= per - 16'h0002 &&
			busy_cnt <= per + 16'(rat) + 16'h0004;
	endproperty
	a_conv_len: assert property (p_conv_len)
		else $error("conversion length wrong");

	// Main scenarios
	c_conv: cover property (O_RESULT_VALID);
	c_cal: cover property ($fell(O_CAL_ACTIVE));
	c_rd: cover property (I_SFR_RD && sel ##1 O_SFR_RDATA[BUSY_BIT]);
endmodule // sacc_checker

`default_nettype wire

// [tb.sv]
// Self-checking bench for the converter calibration control top.
// Assumes sacc_pkg, sacc_top and sacc_checker are compiled first.
`default_nettype none

module tb
	import sacc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk, rst, wr_en, rd_en, conv_start, cmp_hi;
	logic [7:0]  addr, wdata, rdata;
	logic [1:0]  div_sel, acq_sel;
	logic [11:0] vin, dac, result;
	logic        track, cal_act, full, valid, busy;
	int          bad_count, total_checks, trk_cnt;

	sacc_top dut_u (
		.I_CLK(clk), .I_SYS_RST(rst), .I_SFR_ADDR(addr),
		.I_SFR_WDATA(wdata), .I_SFR_WR(wr_en), .I_SFR_RD(rd_en),
		.O_SFR_RDATA(rdata), .I_CLK_DIV_SEL(div_sel), .I_ACQ_SEL(acq_sel),
		.I_CONV_START(conv_start), .I_CMP_HI(cmp_hi), .O_TRACK(track),
		.O_DAC_CODE(dac), .O_CAL_ACTIVE(cal_act), .O_CAL_FULL_SCALE(full),
		.O_RESULT(result), .O_RESULT_VALID(valid), .O_BUSY(busy)
	);

	// ****************************************************************
	// Clock, comparator and common tasks
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Comparator: input at or above the trial code
	always @(negedge clk) cmp_hi <= (vin >= dac);

	// Tracking cycle tally
	always @(negedge clk) begin
		if (track === 1'b1) begin
			trk_cnt++;
		end
	end

	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		check(16'(rdata), 16'(e));
	endtask

	task automatic wait_idle(output int n);
		n = 0;
		@(negedge clk);
		do begin
			@(negedge clk);
			n++;
		end while (busy !== 1'b0 && n < 4000);
		if (n >= 4000) begin
			bad_count++;
			finish_test();
		end
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic conv(input logic [11:0] v, input logic [11:0] e,
		input logic poke);
		int n;
		int t0;
		logic [5:0] r;
		r = (div_sel == DIV_CODE_8)  ? DIV_RATIO_8  :
		    (div_sel == DIV_CODE_4)  ? DIV_RATIO_4  :
		    (div_sel == DIV_CODE_16) ? DIV_RATIO_16 : DIV_RATIO_32;
		t0 = trk_cnt;
		vin = v;
		@(negedge clk);
		conv_start = 1'b1;
		@(negedge clk);
		conv_start = 1'b0;
		if (poke) begin
			wr(SFR_ADDR_CAL_CTRL, 8'h05);
			rchk(SFR_ADDR_CAL_CTRL, 8'h84);
			check(16'(cal_act), 16'h0000);
		end
		wait_idle(n);
		check(16'(valid), 16'h0001);
		check(16'(result), 16'(e));
		check(16'(trk_cnt - t0), 16'(r) * (16'(acq_sel) + 16'h0001));
		@(negedge clk);
		check(16'(busy), 16'h0000);
	endtask

	task automatic cal(input logic [7:0] c, input int nav);
		int n;
		int t;
		wr(SFR_ADDR_CAL_CTRL, c);
		rchk(SFR_ADDR_CAL_CTRL, {1'b1, c[6:0]});
		check(16'(cal_act), 16'h0001);
		check(16'(full), 16'(c[1]));
		wait_idle(n);
		t = (1 + 12 * nav + 3) * 4;
		check(16'(n >= t - 12 && n <= t + 16), 16'h0001);
		rchk(SFR_ADDR_CAL_CTRL, {1'b0, c[6:1], 1'b0});
	endtask

	task automatic convs();
		logic [11:0] v [4] = '{12'h000, 12'hFFF, 12'hA5C, 12'h7FF};
		for (int i = 0; i < 4; i++) begin
			div_sel = 2'(i);
			acq_sel = 2'(3 - i);
			conv(v[i], v[i], 1'b0);
		end
	endtask

	task automatic cals();
		int nt [4] = '{15, 1, 31, 15};
		vin = 12'h010;
		for (int i = 0; i < 4; i++) begin
			cal(8'h05 | 8'(i << 4), nt[i]);
		end
		conv(12'h100, 12'h0F0, 1'b0);
		wr(SFR_ADDR_CAL_CTRL, 8'h08);
		conv(12'h100, 12'h100, 1'b0);
		vin = 12'hFFF;
		cal(8'h17, 1);
		conv(12'h810, 12'h808, 1'b0);
		wr(SFR_ADDR_CAL_CTRL, 8'h40);
		conv(12'h810, 12'h800, 1'b0);
	endtask

	// Main sequence
	initial begin
		{rst, wr_en, rd_en, conv_start} = 4'h8;
		{addr, wdata, div_sel, acq_sel, vin} = 32'h00000000;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		rchk(SFR_ADDR_CAL_CTRL, CAL_CTRL_RESET);
		wr(SFR_ADDR_CAL_CTRL, 8'hFA);
		rchk(SFR_ADDR_CAL_CTRL, 8'h7A);
		check(16'(full), 16'h0001);
		wr(8'hF4, 8'h55);
		rchk(8'hF4, 8'h00);
		rchk(SFR_ADDR_CAL_CTRL, 8'h7A);
		wr(SFR_ADDR_CAL_CTRL, 8'h00);
		convs();
		div_sel = DIV_CODE_4;
		acq_sel = 2'h0;
		conv(12'h3C3, 12'h3C3, 1'b1);
		rchk(SFR_ADDR_CAL_CTRL, 8'h04);
		cals();
		wr(SFR_ADDR_CAL_CTRL, 8'h05);
		repeat (3) @(negedge clk);
		rst = 1'b1;
		@(negedge clk);
		check(16'(busy), 16'h0000);
		rst = 1'b0;
		rchk(SFR_ADDR_CAL_CTRL, CAL_CTRL_RESET);
		conv(12'h810, 12'h810, 1'b0);
		finish_test();
	end
endmodule // tb

bind sacc_top sacc_checker #(.RES_BITS(RES_BITS)) chk_u (
	.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_SFR_ADDR(I_SFR_ADDR),
	.I_SFR_WDATA(I_SFR_WDATA), .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD),
	.O_SFR_RDATA(O_SFR_RDATA), .I_CLK_DIV_SEL(I_CLK_DIV_SEL),
	.I_ACQ_SEL(I_ACQ_SEL), .I_CONV_START(I_CONV_START),
	.I_CMP_HI(I_CMP_HI), .O_TRACK(O_TRACK), .O_DAC_CODE(O_DAC_CODE),
	.O_CAL_ACTIVE(O_CAL_ACTIVE), .O_CAL_FULL_SCALE(O_CAL_FULL_SCALE),
	.O_RESULT(O_RESULT), .O_RESULT_VALID(O_RESULT_VALID), .O_BUSY(O_BUSY)
);

`default_nettype wire
